/* File: port_link_mode_control.sv */
/*
  Per-port link mode control: speed/duplex bring-up by negotiation or
  forced setting, pair crossover, flow control selection, port enable
  and MAC loopback.
  Assumes a line front end that reports partner abilities and detected
  line speed, and a buffer that reports a full level.
*/
// What this block does
// - Negotiate common speed/duplex with partner
// - Non-negotiating partner: detected 10/100 speed, half duplex
// - Negotiation off: use configured speed, duplex
// - Full duplex: pause request when buffers fill
// - Half duplex: fake collision when buffers fill
// - No forced gigabit on twisted pair
// - Detect cable type, swap pairs
// - Crossover only in full automatic mode
// - Loopback setting: none or MAC
// - Per-port flow control enable gates both
// - Auto, forced and negotiated speed choices
// - Disabled port passes nothing, link down
`timescale 1ns/1ps
module port_link_mode_control
  import port_link_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int ANEG_TIMEOUT_CYCLES = ANEG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Management configuration
  input wire logic port_enable,
  input wire logic [3:0] speed_sel,
  input wire logic flow_ctrl_en,
  input wire logic loopback_sel,
  // Line front end and buffer status
  input wire logic line_signal,
  input wire logic [1:0] line_speed,
  input wire logic partner_aneg_valid,
  input wire logic [ABIL_W-1:0] partner_abil,
  input wire logic crossed_cable,
  input wire logic buf_full,
  // Line front end control
  output logic aneg_active,
  output logic [ABIL_W-1:0] adv_abil,
  output logic pair_swap,
  output logic mac_loopback,
  output logic tx_enable,
  output logic rx_enable,
  // Flow control
  output logic pause_req,
  output logic collision_force,
  // Link status
  output logic link_up,
  output logic [1:0] link_speed,
  output logic link_full
);

  ////////////////////////////////////////////////////////////////////////
  // Bring-up state machine

  typedef enum logic [2:0] {
    ST_DOWN,
    ST_SETTLE,
    ST_NEGOTIATE,
    ST_FORCED,
    ST_UP
  } link_st_e;

  link_st_e st_q, st_d;  // Link bring-up state
  logic [31:0] cnt_q, cnt_d;  // Settle / timeout counter
  logic [3:0] sel_q;  // Applied speed selection
  logic fc_q;  // Applied flow control enable
  logic en_q;  // Applied port enable
  logic cfg_change;  // Speed, flow control or enable setting changed
  logic up_q, up_d;
  logic [1:0] spd_q, spd_d;
  logic full_q, full_d;
  logic swap_q, swap_d;
  logic aneg_q, aneg_d;
  logic [ABIL_W-1:0] adv_q, adv_d;
  logic loop_q;
  logic txen_q, txen_d;  // Transmit path gate
  logic rxen_q, rxen_d;  // Receive path gate

  // Decoded selection
  logic sel_is_auto;
  logic sel_is_neg;
  logic [1:0] sel_speed;
  logic sel_full;
  logic [ABIL_W-1:0] sel_abil;

  // Resolver outputs
  logic [1:0] res_speed;
  logic res_full;
  logic res_ok;

  ////////////////////////////////////////////////////////////////////////
  // Selection decode

  // Map speed selection onto mode, speed, duplex and advertisement
  always_comb begin
    sel_is_auto = 1'b0;
    sel_is_neg = 1'b1;
    sel_speed = SPEED_10;
    sel_full = 1'b0;
    sel_abil = '0;
    case (speed_sel_e'(sel_q))
      SD_AUTO: begin
        sel_is_auto = 1'b1;
        sel_abil = ABIL_ALL;
      end
      SD_10_FULL: begin
        sel_is_neg = 1'b0;
        sel_full = 1'b1;
      end
      SD_10_FULL_N: sel_abil[ABIL_10F] = 1'b1;
      SD_10_HALF: sel_is_neg = 1'b0;
      SD_10_HALF_N: sel_abil[ABIL_10H] = 1'b1;
      SD_100_FULL: begin
        sel_is_neg = 1'b0;
        sel_speed = SPEED_100;
        sel_full = 1'b1;
      end
      SD_100_FULL_N: sel_abil[ABIL_100F] = 1'b1;
      SD_100_HALF: begin
        sel_is_neg = 1'b0;
        sel_speed = SPEED_100;
      end
      SD_100_HALF_N: sel_abil[ABIL_100H] = 1'b1;
      // Forced gigabit is not allowed: negotiate 1000 full only
      SD_1000_FULL: sel_abil[ABIL_1000F] = 1'b1;
      SD_1000_FULL_N: sel_abil[ABIL_1000F] = 1'b1;
      default: begin
        sel_is_auto = 1'b1;
        sel_abil = ABIL_ALL;
      end
    endcase
  end

  // Best common mode with the partner
  ability_resolve u_resolve (
    .local_abil(sel_abil),
    .partner_abil(partner_abil),
    .res_speed(res_speed),
    .res_full(res_full),
    .res_ok(res_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // Applied settings

  // A change to the speed, flow control or enable setting restarts this port only; loopback does not
  assign cfg_change = (speed_sel != sel_q) || (flow_ctrl_en != fc_q) || (port_enable != en_q);

  // Capture settings every cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_q <= 4'h0;
      fc_q <= 1'b0;
      en_q <= 1'b0;
      loop_q <= LOOP_NONE;
    end else begin
      sel_q <= speed_sel;
      fc_q <= flow_ctrl_en;
      en_q <= port_enable;
      loop_q <= loopback_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link state next values

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    up_d = up_q;
    spd_d = spd_q;
    full_d = full_q;
    swap_d = swap_q;
    aneg_d = 1'b0;
    adv_d = adv_q;
    case (st_q)
      // Link held down, wait for enable and signal
      ST_DOWN: begin
        up_d = 1'b0;
        spd_d = SPEED_NONE;
        full_d = 1'b0;
        if (en_q && line_signal) begin
          st_d = ST_SETTLE;
          cnt_d = '0;
        end
      end
      // Quiet time, then choose negotiated or forced path
      ST_SETTLE: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(SETTLE_CYCLES - 1)) begin
          cnt_d = '0;
          adv_d = sel_abil;
          // Crossover only in full automatic mode
          swap_d = sel_is_auto ? crossed_cable : 1'b0;
          st_d = sel_is_neg ? ST_NEGOTIATE : ST_FORCED;
        end
      end
      // Exchange abilities, or time out on a silent partner
      ST_NEGOTIATE: begin
        aneg_d = 1'b1;
        cnt_d = cnt_q + 32'h1;
        if (partner_aneg_valid && res_ok) begin
          spd_d = res_speed;
          full_d = res_full;
          up_d = 1'b1;
          st_d = ST_UP;
        end else if (cnt_q >= 32'(ANEG_TIMEOUT_CYCLES - 1)) begin
          if (line_speed != SPEED_1000 && line_speed != SPEED_NONE) begin
            spd_d = line_speed;
            full_d = 1'b0;
            up_d = 1'b1;
            st_d = ST_UP;
          end else begin
            st_d = ST_DOWN;
          end
        end
      end
      // Configured values only, no exchange
      ST_FORCED: begin
        spd_d = sel_speed;
        full_d = sel_full;
        up_d = 1'b1;
        st_d = ST_UP;
      end
      // Running; drop on loss of signal
      ST_UP: begin
        if (!line_signal) begin
          st_d = ST_DOWN;
        end
      end
      default: st_d = ST_DOWN;
    endcase
    // Disable or setting change forces a restart
    if (!en_q || cfg_change) begin
      st_d = ST_DOWN;
      up_d = 1'b0;
      spd_d = SPEED_NONE;
      full_d = 1'b0;
      aneg_d = 1'b0;
    end
  end

  // Link state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_DOWN;
      cnt_q <= '0;
      up_q <= 1'b0;
      spd_q <= SPEED_NONE;
      full_q <= 1'b0;
      swap_q <= 1'b0;
      aneg_q <= 1'b0;
      adv_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      up_q <= up_d;
      spd_q <= spd_d;
      full_q <= full_d;
      swap_q <= swap_d;
      aneg_q <= aneg_d;
      adv_q <= adv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath gating

  // Disabled port neither sends nor receives
  always_comb begin
    txen_d = en_q && up_q;
    rxen_d = en_q && up_q;
  end

  // Gate registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txen_q <= 1'b0;
      rxen_q <= 1'b0;
    end else begin
      txen_q <= txen_d;
      rxen_q <= rxen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flow control

  flow_ctrl_gen u_fc (
    .clk_sys(clk_sys),
    .rst(rst),
    .link_up(up_q),
    .full_duplex(full_q),
    .fc_enable(fc_q),
    .buf_full(buf_full),
    .pause_req(pause_req),
    .backpressure(collision_force)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign aneg_active = aneg_q;
  assign adv_abil = adv_q;
  assign pair_swap = swap_q;
  assign mac_loopback = loop_q;
  assign tx_enable = txen_q;
  assign rx_enable = rxen_q;
  assign link_up = up_q;
  assign link_speed = spd_q;
  assign link_full = full_q;

endmodule : port_link_mode_control

/* File: port_link_pkg.sv */
/*
  Shared constants and types for the per-port link mode control block.
  Assumes a single clock domain; no other dependencies.
*/
package port_link_pkg;

  // Speed/duplex selection codes
  typedef enum logic [3:0] {
    SD_AUTO       = 4'h0,
    SD_10_FULL    = 4'h1,
    SD_10_FULL_N  = 4'h2,
    SD_10_HALF    = 4'h3,
    SD_10_HALF_N  = 4'h4,
    SD_100_FULL   = 4'h5,
    SD_100_FULL_N = 4'h6,
    SD_100_HALF   = 4'h7,
    SD_100_HALF_N = 4'h8,
    SD_1000_FULL  = 4'h9,
    SD_1000_FULL_N = 4'hA
  } speed_sel_e;

  // Resolved speed encoding
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_NONE = 2'h3;

  // Ability vector bit positions: {1000F, 100F, 100H, 10F, 10H}
  localparam int ABIL_10H = 0;
  localparam int ABIL_10F = 1;
  localparam int ABIL_100H = 2;
  localparam int ABIL_100F = 3;
  localparam int ABIL_1000F = 4;
  localparam int ABIL_W = 5;
  localparam logic [4:0] ABIL_ALL = 5'h1F;

  // Loopback settings
  localparam logic LOOP_NONE = 1'b0;
  localparam logic LOOP_MAC = 1'b1;

  // Bring-up timing: settle time after a restart, and negotiation timeout
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int ANEG_TIMEOUT_US = 100;
  localparam int ANEG_TIMEOUT_CYC = ANEG_TIMEOUT_US * CLK_MHZ;

endpackage : port_link_pkg

/* File: ability_resolve.sv */
/*
  Picks the best common speed/duplex from two ability vectors.
  Assumes ability bits laid out as in port_link_pkg.
*/
`timescale 1ns/1ps
module ability_resolve
  import port_link_pkg::*;
(
  // Ability vectors
  input wire logic [ABIL_W-1:0] local_abil,
  input wire logic [ABIL_W-1:0] partner_abil,
  // Result
  output logic [1:0] res_speed,
  output logic res_full,
  output logic res_ok
);

  logic [ABIL_W-1:0] common;  // Shared abilities

  // Highest common ability wins
  always_comb begin
    common = local_abil & partner_abil;
    res_ok = 1'b1;
    res_speed = SPEED_NONE;
    res_full = 1'b0;
    if (common[ABIL_1000F]) begin
      res_speed = SPEED_1000;
      res_full = 1'b1;
    end else if (common[ABIL_100F]) begin
      res_speed = SPEED_100;
      res_full = 1'b1;
    end else if (common[ABIL_100H]) begin
      res_speed = SPEED_100;
    end else if (common[ABIL_10F]) begin
      res_speed = SPEED_10;
      res_full = 1'b1;
    end else if (common[ABIL_10H]) begin
      res_speed = SPEED_10;
    end else begin
      res_ok = 1'b0;
    end
  end

endmodule : ability_resolve

/* File: flow_ctrl_gen.sv */
/*
  Turns a buffer-full level into pause or backpressure requests.
  Assumes inputs synchronous to clk_sys.
*/
`timescale 1ns/1ps
module flow_ctrl_gen
  import port_link_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Controls
  input wire logic link_up,
  input wire logic full_duplex,
  input wire logic fc_enable,
  input wire logic buf_full,
  // Requests
  output logic pause_req,
  output logic backpressure
);

  logic full_q;  // Last buffer-full level
  logic pause_d;
  logic pause_q;
  logic bp_d;
  logic bp_q;

  // Pause pulses on full rising; backpressure holds while full
  always_comb begin
    pause_d = link_up && fc_enable && full_duplex && buf_full && !full_q;
    bp_d = link_up && fc_enable && !full_duplex && buf_full;
  end

  // Register stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      full_q <= 1'b0;
      pause_q <= 1'b0;
      bp_q <= 1'b0;
    end else begin
      full_q <= buf_full;
      pause_q <= pause_d;
      bp_q <= bp_d;
    end
  end

  assign pause_req = pause_q;
  assign backpressure = bp_q;

endmodule : flow_ctrl_gen

/* File: port_link_mode_control_asserts.sv */
/*
  Concurrent checks on the link mode control ports.
  Assumes one clock domain and a bind onto the design's top module.
*/
`timescale 1ns/1ps
module port_link_mode_control_asserts
  import port_link_pkg::*;
#(
  parameter int SETTLE_CYCLES = 4,
  parameter int ANEG_TIMEOUT_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration, line and buffer status
  input wire logic port_enable,
  input wire logic [3:0] speed_sel,
  input wire logic flow_ctrl_en,
  input wire logic loopback_sel,
  input wire logic crossed_cable,
  input wire logic buf_full,
  // Watched outputs
  input wire logic aneg_active,
  input wire logic [ABIL_W-1:0] adv_abil,
  input wire logic pair_swap,
  input wire logic mac_loopback,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic pause_req,
  input wire logic collision_force,
  input wire logic link_up,
  input wire logic link_full
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Advertised abilities for each negotiating selection
  function automatic logic [4:0] adv_of(input logic [3:0] s);
    case (s)
      4'h2: adv_of = 5'h02;
      4'h4: adv_of = 5'h01;
      4'h6: adv_of = 5'h08;
      4'h8: adv_of = 5'h04;
      4'h9, 4'hA: adv_of = 5'h10; // Gigabit only by negotiation
      default: adv_of = ABIL_ALL;
    endcase
  endfunction : adv_of
  // Buffer fills on a full duplex link
  sequence s_fill_full;
    $rose(buf_full) && link_up && link_full && flow_ctrl_en;
  endsequence
  // One-cycle pause pulse
  sequence s_pulse;
    pause_req ##1 !pause_req;
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_ADV: assert property (
    aneg_active && speed_sel == $past(speed_sel, 3) |-> adv_abil == adv_of(speed_sel)) else $error("adv wrong");
  AST_FORCED: assert property (
    speed_sel inside {SD_10_FULL, SD_10_HALF, SD_100_FULL, SD_100_HALF} && speed_sel == $past(speed_sel, 4)
    |-> !aneg_active) else $error("forced negotiates");
  AST_SWAP: assert property (
    $rose(link_up) |-> pair_swap == (crossed_cable && speed_sel == SD_AUTO)) else $error("swap wrong");
  AST_LOOP: assert property (
    mac_loopback == $past(loopback_sel)) else $error("loopback wrong");
  AST_TXRX: assert property (
    tx_enable || rx_enable |-> $past(link_up)) else $error("tx rx without link");
  AST_DIS: assert property (
    !port_enable [*3] |-> !link_up && !tx_enable && !rx_enable) else $error("disabled port up");
  AST_PAUSE: assert property (
    s_fill_full |=> s_pulse) else $error("no pause pulse");
  AST_PGATE: assert property (
    pause_req |-> $past(flow_ctrl_en) && $past(link_full)) else $error("pause not gated");
  AST_BP: assert property (
    buf_full && link_up && !link_full && flow_ctrl_en |=> collision_force) else $error("no backpressure");
  AST_BGATE: assert property (
    collision_force |-> $past(flow_ctrl_en) && $past(buf_full) && !$past(link_full)) else $error("bp not gated");
endmodule : port_link_mode_control_asserts

bind port_link_mode_control port_link_mode_control_asserts #(
  .SETTLE_CYCLES(SETTLE_CYCLES),
  .ANEG_TIMEOUT_CYCLES(ANEG_TIMEOUT_CYCLES)
) chk_inst (.clk_sys(clk_sys), .rst(rst), .port_enable(port_enable), .speed_sel(speed_sel),
  .flow_ctrl_en(flow_ctrl_en), .loopback_sel(loopback_sel), .crossed_cable(crossed_cable),
  .buf_full(buf_full), .aneg_active(aneg_active), .adv_abil(adv_abil), .pair_swap(pair_swap),
  .mac_loopback(mac_loopback), .tx_enable(tx_enable), .rx_enable(rx_enable), .pause_req(pause_req),
  .collision_force(collision_force), .link_up(link_up), .link_full(link_full));

/* File: link_partner_model.sv */
/*
  Behavioural remote link partner port.
  Assumes its setup inputs come from the bench.
*/
`timescale 1ns/1ps
module link_partner_model (
  // Clock
  input wire logic clk_sys,
  // Setup from the bench
  input wire logic p_on,
  input wire logic p_aneg,
  input wire logic p_cross,
  input wire logic [1:0] p_speed,
  input wire logic [4:0] p_abil,
  // Device requests
  input wire logic aneg_active,
  input wire logic pause_req,
  input wire logic collision_force,
  // Line status to the device
  output logic line_signal,
  output logic [1:0] line_speed,
  output logic partner_aneg_valid,
  output logic [4:0] partner_abil,
  output logic crossed_cable,
  output logic sending
);
  logic [3:0] an_cnt_q = 4'h0; // Negotiation cycles seen
  logic [3:0] hold_q = 4'h0; // Hold-off time left
  // Negotiation delay and transmit hold-off
  always @(posedge clk_sys) begin
    if (!(aneg_active && p_on)) begin
      an_cnt_q <= 4'h0;
    end else if (an_cnt_q != 4'hF) begin
      an_cnt_q <= an_cnt_q + 4'h1;
    end
    if (pause_req || collision_force) begin
      hold_q <= 4'hF; // Stop sending
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1; // Resume later
    end
  end
  // Line outputs
  assign line_signal = p_on;
  assign line_speed = p_on ? p_speed : 2'h3; // Matches forced setting
  assign partner_aneg_valid = p_aneg && p_on && (an_cnt_q >= 4'h3);
  assign partner_abil = partner_aneg_valid ? p_abil : ~p_abil; // No stale value
  assign crossed_cable = p_cross;
  assign sending = p_on && (hold_q == 4'h0);
endmodule : link_partner_model

/* File: port_link_mode_control_tb.sv */
/*
  Self-checking bench for the link mode control block.
  Assumes the partner model faces the line side.
*/
`timescale 1ns/1ps
module port_link_mode_control_tb
  import port_link_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic port_enable = 1'b1;
  logic [3:0] speed_sel = 4'h0;
  logic flow_ctrl_en = 1'b1;
  logic loopback_sel = 1'b0;
  logic buf_full = 1'b0;
  logic p_on = 1'b0, p_aneg = 1'b0, p_cross = 1'b0;
  logic [1:0] p_speed = 2'h0;
  logic [4:0] p_abil = 5'h00;
  logic line_signal, partner_aneg_valid, crossed_cable, sending;
  logic [1:0] line_speed, link_speed;
  logic [4:0] partner_abil, adv_abil;
  logic aneg_active, pair_swap, mac_loopback, tx_enable, rx_enable;
  logic pause_req, collision_force, link_up, link_full;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [4:0] adv_tbl [11] = '{5'h1F, 5'h02, 5'h02, 5'h01, 5'h01, 5'h08, 5'h08, 5'h04, 5'h04, 5'h10, 5'h10};
  ////////////////////////////////////////////////////////////////
  always #2.5 clk_sys = ~clk_sys;
  port_link_mode_control #(.SETTLE_CYCLES(4), .ANEG_TIMEOUT_CYCLES(20)) port_link_mode_control_inst (
    .clk_sys(clk_sys), .rst(rst), .port_enable(port_enable), .speed_sel(speed_sel), .flow_ctrl_en(flow_ctrl_en),
    .loopback_sel(loopback_sel), .line_signal(line_signal), .line_speed(line_speed),
    .partner_aneg_valid(partner_aneg_valid), .partner_abil(partner_abil), .crossed_cable(crossed_cable),
    .buf_full(buf_full), .aneg_active(aneg_active), .adv_abil(adv_abil), .pair_swap(pair_swap),
    .mac_loopback(mac_loopback), .tx_enable(tx_enable), .rx_enable(rx_enable), .pause_req(pause_req),
    .collision_force(collision_force), .link_up(link_up), .link_speed(link_speed), .link_full(link_full));
  link_partner_model link_partner_model_inst (.clk_sys(clk_sys), .p_on(p_on), .p_aneg(p_aneg), .p_cross(p_cross),
    .p_speed(p_speed), .p_abil(p_abil), .aneg_active(aneg_active), .pause_req(pause_req),
    .collision_force(collision_force), .line_signal(line_signal), .line_speed(line_speed),
    .partner_aneg_valid(partner_aneg_valid), .partner_abil(partner_abil), .crossed_cable(crossed_cable),
    .sending(sending));
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task check(input string name, input logic [4:0] exp, input logic [4:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task wait_up;
    for (int i = 0; i < 300 && link_up !== 1'b1; i++) tick(1);
    check("link_up", 5'h01, 5'(link_up));
    tick(2);
  endtask : wait_up
  // Drop the line, set up both ends, wait for link
  task link(input logic [3:0] sel, input logic an, input logic [4:0] ab, input logic [1:0] sp, input logic cr);
    p_on = 1'b0;
    tick(3);
    speed_sel = sel;
    p_aneg = an;
    p_abil = ab;
    p_speed = sp;
    p_cross = cr;
    p_on = 1'b1;
    wait_up();
  endtask : link
  ////////////////////////////////////////////////////////////////
  task t_auto;
    link(SD_AUTO, 1'b1, 5'h0E, SPEED_100, 1'b1);
    check("link_speed", 5'(SPEED_100), 5'(link_speed));
    check("link_full", 5'h01, 5'(link_full));
    check("pair_swap", 5'h01, 5'(pair_swap));
    check("adv_abil", ABIL_ALL, adv_abil);
    check("tx_enable", 5'h01, 5'(tx_enable));
  endtask : t_auto
  // Every forced and negotiated selection
  task t_modes;
    logic neg;
    for (logic [3:0] c = 4'h1; c <= 4'hA; c++) begin
      neg = (c[0] == 1'b0) || (c == 4'h9);
      link(c, neg, ABIL_ALL, (c <= 4'h4) ? SPEED_10 : (c <= 4'h8) ? SPEED_100 : SPEED_1000, 1'b1);
      check("link_speed", 5'((c <= 4'h4) ? SPEED_10 : (c <= 4'h8) ? SPEED_100 : SPEED_1000), 5'(link_speed));
      check("link_full", 5'(c inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA}), 5'(link_full));
      check("pair_swap", 5'h00, 5'(pair_swap));
      if (neg) check("adv_abil", adv_tbl[c], adv_abil);
    end
  endtask : t_modes
  // Silent partner, then half duplex backpressure
  task t_fallback;
    link(SD_AUTO, 1'b0, ABIL_ALL, SPEED_10, 1'b0);
    check("link_speed", 5'(SPEED_10), 5'(link_speed));
    check("link_full", 5'h00, 5'(link_full));
    buf_full = 1'b1;
    tick(2);
    check("collision_force", 5'h01, 5'(collision_force));
    check("pause_req", 5'h00, 5'(pause_req));
    buf_full = 1'b0;
    tick(2);
    check("collision_force", 5'h00, 5'(collision_force));
  endtask : t_fallback
  // Pause pulse, then flow control off
  task t_pause;
    link(SD_100_FULL_N, 1'b1, ABIL_ALL, SPEED_100, 1'b0);
    buf_full = 1'b1;
    tick(1);
    check("pause_req", 5'h01, 5'(pause_req));
    tick(1);
    check("pause_req", 5'h00, 5'(pause_req));
    check("sending", 5'h00, 5'(sending));
    buf_full = 1'b0;
    flow_ctrl_en = 1'b0;
    tick(5);
    check("link_up", 5'h00, 5'(link_up));
    wait_up();
    buf_full = 1'b1;
    tick(2);
    check("pause_req", 5'h00, 5'(pause_req));
    check("collision_force", 5'h00, 5'(collision_force));
    buf_full = 1'b0;
    flow_ctrl_en = 1'b1;
    tick(2);
    wait_up();
  endtask : t_pause
  // Disable, re-enable, loopback
  task t_admin;
    port_enable = 1'b0;
    tick(5);
    check("link_up", 5'h00, 5'(link_up));
    check("rx_enable", 5'h00, 5'(rx_enable));
    port_enable = 1'b1;
    wait_up();
    check("link_up", 5'h01, 5'(link_up));
    loopback_sel = LOOP_MAC;
    tick(1);
    check("mac_loopback", 5'h01, 5'(mac_loopback));
    loopback_sel = LOOP_NONE;
    tick(1);
    check("mac_loopback", 5'h00, 5'(mac_loopback));
  endtask : t_admin
  ////////////////////////////////////////////////////////////////
  task give_verdict;
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    tick(4);
    rst = 1'b0;
    check("link_speed", 5'h03, 5'(link_speed));
    t_auto();
    t_modes();
    t_fallback();
    t_pause();
    t_admin();
    give_verdict();
  end
endmodule : port_link_mode_control_tb
